// ==== verilog/esc_consts.svh ====
// esc_consts.svh: status codes, protection code and command byte for the status logic
// assumes inclusion by esc_status_logic only
`ifndef ESC_CONSTS_SVH
`define ESC_CONSTS_SVH
`define ESC_ST_OK 8'h00
`define ESC_ST_ALIGN 8'h01
`define ESC_ST_OFFSET 8'h02
`define ESC_ST_PART 8'h03
`define ESC_ST_ALIM 8'h04
`define ESC_ST_IBUS 8'h05
`define ESC_ST_ICSUM 8'h06
`define ESC_ST_WDOG 8'h07
`define ESC_ST_PARITY 8'h09
`define ESC_ST_FCSUM 8'h0A
`define ESC_ST_UNKCMD 8'h0B
`define ESC_ST_LEN 8'h0C
`define ESC_ST_ARG 8'h0D
`define ESC_ST_WPROT 8'h0E
`define ESC_ST_CODE 8'h0F
`define ESC_ST_RESIZE 8'h10
`define ESC_ST_ADDR 8'h11
`define ESC_ST_NOFIELD 8'h12
`define ESC_ST_ANAMON 8'h1C
`define ESC_ST_CURR 8'h1D
`define ESC_ST_SPEED 8'h1F
`define ESC_CODE0_RESET 8'h55
`define ESC_CMD_STATUS 8'h50
`endif

// ==== verilog/esc_pkg.sv ====
// esc_pkg: types for the encoder status code logic
// assumes the constants header is available on the include path
package esc_pkg;
    typedef logic [7:0] esc_byte_t;
    typedef enum logic [0:0] {
        ESC_IDLE = 1'b0,
        ESC_ANSWER = 1'b1
    } esc_state_t;
endpackage : esc_pkg

// ==== verilog/esc_status_logic.sv ====
// esc_status_logic: picks one status byte from fault events and answers status reads
// assumes all event inputs are one-cycle pulses or levels synchronous to core_clk_in
// Function
// [RULE1] no fault present gives status 00h
// [RULE2] initialization faults give 01h to 06h by cause
// [RULE3] supervision restart reports 07h afterwards
// [RULE4] parity error gives 09h, frame checksum error gives 0Ah
// [RULE5] unknown command gives 0Bh, wrong data count gives 0Ch
// [RULE6] argument outside allowed set gives 0Dh
// [RULE7] write to protected field is refused, status 0Eh
// [RULE8] wrong access code gives 0Fh, failed resize gives 10h
// [RULE9] word address beyond field is rejected, status 11h
// [RULE10] access to missing field is rejected, status 12h
// [RULE11] speed too high for position gives 1Fh
// [RULE12] analog signal monitoring violation gives 1Ch
// [RULE13] transmitter current critical or work memory error gives 1Dh
// [RULE14] protection code byte holds 55h as delivered
// [RULE15] latest status held and returned on status read command
`timescale 1ns/1ps
`include "esc_consts.svh"
module esc_status_logic
    import esc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,

    // initialization fault events
    input wire logic init_align_err_in,
    input wire logic init_offset_err_in,
    input wire logic init_part_err_in,
    input wire logic init_alim_err_in,
    input wire logic init_ibus_err_in,
    input wire logic init_csum_err_in,

    // protocol and command events
    input wire logic wdog_restart_in,
    input wire logic parity_err_in,
    input wire logic frame_csum_err_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic cmd_known_in,
    input wire logic len_err_in,
    input wire logic arg_err_in,

    // data field access events
    input wire logic wr_req_in,
    input wire logic field_wprot_in,
    input wire logic code_valid_in,
    input wire logic [7:0] code_in,
    input wire logic code_load_in,
    input wire logic resize_fail_in,
    input wire logic addr_out_of_field_in,
    input wire logic field_missing_in,

    // position and monitoring events
    input wire logic overspeed_in,
    input wire logic analog_mon_err_in,
    input wire logic tx_current_crit_in,
    input wire logic work_mem_err_in,

    // status housekeeping
    input wire logic status_clear_in,

    // registered results, each straight from a flip-flop
    output logic [7:0] status_out,
    output logic status_valid_out,
    output logic [7:0] status_reply_out,
    output logic wr_refused_out,
    output logic access_reject_out,
    output logic [7:0] code0_out
);
    esc_byte_t status_r;
    esc_byte_t status_nxt;
    esc_byte_t code0_r;
    esc_byte_t reply_r;
    esc_byte_t init_code;
    esc_byte_t proto_code;
    esc_byte_t data_code;
    esc_byte_t sev_code;
    esc_state_t state_r;
    esc_state_t state_nxt;
    logic valid_r;
    logic refuse_r;
    logic reject_r;

    // initialization causes
    wire hit_align = init_align_err_in; // see [RULE2]
    wire hit_offset = init_offset_err_in; // see [RULE2]
    wire hit_part = init_part_err_in; // see [RULE2]
    wire hit_alim = init_alim_err_in; // see [RULE2]
    wire hit_ibus = init_ibus_err_in; // see [RULE2]
    wire hit_icsum = init_csum_err_in; // see [RULE2]

    // protocol causes
    wire hit_wdog = wdog_restart_in; // see [RULE3]
    wire hit_parity = parity_err_in; // see [RULE4]
    wire hit_fcsum = frame_csum_err_in; // see [RULE4]
    wire hit_unkcmd = cmd_valid_in && !cmd_known_in; // see [RULE5]
    wire hit_len = len_err_in; // see [RULE5]
    wire hit_arg = arg_err_in; // see [RULE6]

    // data field causes; a code mismatch only counts when a code is supplied
    wire hit_wprot = wr_req_in && field_wprot_in; // see [RULE7]
    wire hit_code = code_valid_in && (code_in != code0_r); // see [RULE8]
    wire hit_resize = resize_fail_in; // see [RULE8]
    wire hit_addr = addr_out_of_field_in; // see [RULE9]
    wire hit_nofield = field_missing_in; // see [RULE10]

    // position and monitoring causes
    wire hit_anamon = analog_mon_err_in; // see [RULE12]
    wire hit_curr = tx_current_crit_in || work_mem_err_in; // see [RULE13]
    wire hit_speed = overspeed_in; // see [RULE11]

    // command decode and side outputs
    wire status_rd = cmd_valid_in && cmd_known_in && (cmd_byte_in == `ESC_CMD_STATUS);
    wire reject_now = hit_addr || hit_nofield; // see [RULE9] see [RULE10]
    wire code_load_ok = code_load_in && code_valid_in && !hit_code;

    // one flag per group lets the final chain rank groups, not single causes
    wire init_any = hit_align || hit_offset || hit_part || hit_alim || hit_ibus || hit_icsum;
    wire proto_any = hit_wdog || hit_parity || hit_fcsum || hit_unkcmd || hit_len || hit_arg;
    wire data_any = hit_wprot || hit_code || hit_resize || hit_addr || hit_nofield;
    wire sev_any = hit_anamon || hit_curr || hit_speed;

    // within a group the later cause wins
    always_comb begin
        init_code = `ESC_ST_OK;
        if (hit_align) begin
            init_code = `ESC_ST_ALIGN; // see [RULE2]
        end
        if (hit_offset) begin
            init_code = `ESC_ST_OFFSET; // see [RULE2]
        end
        if (hit_part) begin
            init_code = `ESC_ST_PART; // see [RULE2]
        end
        if (hit_alim) begin
            init_code = `ESC_ST_ALIM; // see [RULE2]
        end
        if (hit_ibus) begin
            init_code = `ESC_ST_IBUS; // see [RULE2]
        end
        if (hit_icsum) begin
            init_code = `ESC_ST_ICSUM; // see [RULE2]
        end
    end

    always_comb begin
        proto_code = `ESC_ST_OK;
        if (hit_wdog) begin
            proto_code = `ESC_ST_WDOG; // see [RULE3]
        end
        if (hit_parity) begin
            proto_code = `ESC_ST_PARITY; // see [RULE4]
        end
        if (hit_fcsum) begin
            proto_code = `ESC_ST_FCSUM; // see [RULE4]
        end
        if (hit_unkcmd) begin
            proto_code = `ESC_ST_UNKCMD; // see [RULE5]
        end
        if (hit_len) begin
            proto_code = `ESC_ST_LEN; // see [RULE5]
        end
        if (hit_arg) begin
            proto_code = `ESC_ST_ARG; // see [RULE6]
        end
    end

    always_comb begin
        data_code = `ESC_ST_OK;
        if (hit_wprot) begin
            data_code = `ESC_ST_WPROT; // see [RULE7]
        end
        if (hit_code) begin
            data_code = `ESC_ST_CODE; // see [RULE8]
        end
        if (hit_resize) begin
            data_code = `ESC_ST_RESIZE; // see [RULE8]
        end
        if (hit_addr) begin
            data_code = `ESC_ST_ADDR; // see [RULE9]
        end
        if (hit_nofield) begin
            data_code = `ESC_ST_NOFIELD; // see [RULE10]
        end
    end

    always_comb begin
        sev_code = `ESC_ST_OK;
        if (hit_anamon) begin
            sev_code = `ESC_ST_ANAMON; // see [RULE12]
        end
        if (hit_curr) begin
            sev_code = `ESC_ST_CURR; // see [RULE13]
        end
        if (hit_speed) begin
            sev_code = `ESC_ST_SPEED; // see [RULE11]
        end
    end

    // groups rank init, protocol, data, then position and monitoring; a clear in
    // the same cycle as any event loses, so a clear never drops a fault raised in its own cycle
    always_comb begin
        status_nxt = status_r;
        if (status_clear_in) begin
            status_nxt = `ESC_ST_OK; // see [RULE1]
        end
        if (init_any) begin
            status_nxt = init_code; // see [RULE2]
        end
        if (proto_any) begin
            status_nxt = proto_code; // see [RULE3] see [RULE4] see [RULE5] see [RULE6]
        end
        if (data_any) begin
            status_nxt = data_code; // see [RULE7] see [RULE8] see [RULE9] see [RULE10]
        end
        if (sev_any) begin
            status_nxt = sev_code; // see [RULE11] see [RULE12] see [RULE13]
        end
    end

    // a read in the answer cycle is answered again, so reads may come back to back
    always_comb begin
        state_nxt = ESC_IDLE;
        case (state_r)
            ESC_IDLE: begin
                if (status_rd) begin
                    state_nxt = ESC_ANSWER;
                end
            end
            ESC_ANSWER: begin
                if (status_rd) begin
                    state_nxt = ESC_ANSWER;
                end
            end
            default: begin
                state_nxt = ESC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_r <= `ESC_ST_OK; // see [RULE1]
        end else begin
            status_r <= status_nxt; // see [RULE15]
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ESC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // valid has its own flop so the output needs no decode after the register
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= (state_nxt == ESC_ANSWER); // see [RULE15]
        end
    end

    // reply carries the status held before this read's own cycle
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reply_r <= `ESC_ST_OK;
        end else if (status_rd) begin
            reply_r <= status_r; // see [RULE15]
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            refuse_r <= 1'b0;
        end else begin
            refuse_r <= hit_wprot; // see [RULE7]
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reject_r <= 1'b0;
        end else begin
            reject_r <= reject_now; // see [RULE9] see [RULE10]
        end
    end

    // protection code; a load is only honoured when code_in equals the stored code,
    // so a stray load can never unlock the critical parameters
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            code0_r <= `ESC_CODE0_RESET; // see [RULE14]
        end else if (code_load_ok) begin
            code0_r <= code_in;
        end
    end

    assign status_out = status_r;
    assign status_valid_out = valid_r;
    assign status_reply_out = reply_r;
    assign wr_refused_out = refuse_r;
    assign access_reject_out = reject_r;
    assign code0_out = code0_r;
endmodule : esc_status_logic

// ==== test/esc_status_logic_checker.sv ====
// esc_status_logic_checker: timing and code checks at the status logic ports
// assumes a bind onto esc_status_logic
`timescale 1ns/1ps
module esc_status_logic_checker (
    input wire logic core_clk_in, resetn_in, overspeed_in, tx_current_crit_in,
    input wire logic work_mem_err_in, analog_mon_err_in, wr_req_in, field_wprot_in,
    input wire logic addr_out_of_field_in, field_missing_in, cmd_valid_in, cmd_known_in,
    input wire logic [7:0] cmd_byte_in, status_out, status_reply_out, code0_out,
    input wire logic status_valid_out, wr_refused_out, access_reject_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    wire rd = cmd_valid_in & cmd_known_in & (cmd_byte_in == 8'h50);
    wire wp = wr_req_in & field_wprot_in;
    wire hot = overspeed_in | tx_current_crit_in | work_mem_err_in;
    AST_SPEED: assert property (overspeed_in |=> status_out == 8'h1F) else $error("speed");
    AST_CURR: assert property (tx_current_crit_in & !overspeed_in |=> status_out == 8'h1D)
        else $error("current");
    AST_ANA: assert property (analog_mon_err_in & !hot |=> status_out == 8'h1C) else $error("ana");
    AST_CODE0: assert property (code0_out == 8'h55) else $error("code0");
    AST_WPROT: assert property (wp |=> wr_refused_out) else $error("refuse");
    AST_NOWP: assert property (!wp |=> !wr_refused_out) else $error("refuse idle");
    AST_REJ: assert property (addr_out_of_field_in | field_missing_in |=> access_reject_out)
        else $error("reject");
    AST_READ: assert property (rd |=> status_valid_out && status_reply_out == $past(status_out))
        else $error("reply");
    AST_NORD: assert property (!rd |=> !status_valid_out) else $error("valid");
    cover property (rd);
    cover property (overspeed_in ##1 rd);
    cover property (wr_refused_out);
endmodule : esc_status_logic_checker

// ==== test/esc_ctrl_model.sv ====
// esc_ctrl_model: drive controller side that sends command bytes
// assumes its inputs change at the falling edge
`timescale 1ns/1ps
module esc_ctrl_model (
    input wire logic go_in,
    input wire logic known_in,
    input wire logic [7:0] byte_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_byte_out,
    output logic cmd_known_out
);
    // idle byte inverted so a stale byte never looks like a fresh command
    assign cmd_valid_out = go_in;
    assign cmd_byte_out = go_in ? byte_in : ~byte_in;
    assign cmd_known_out = go_in & known_in;
endmodule : esc_ctrl_model

// ==== test/tb_esc_status_logic.sv ====
// tb_esc_status_logic: random and directed events against a priority model
// assumes the design and checker files are compiled first
`timescale 1ns/1ps
module tb_esc_status_logic;
    logic core_clk_in = 0, resetn_in = 0, go = 0, known = 0, sv, wref, arej, ck, cv;
    logic [21:0] e = '0;
    logic [31:0] r;
    logic [7:0] bv = 8'h00, ex = 8'h00, so, rep, c0, cb;
    logic [7:0] cd [0:20] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0A,
        8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h1C, 8'h1D, 8'h1D, 8'h1F};
    integer n_errors = 0, n_compared = 0, seed = 32'h1aa1_a3da;
    esc_ctrl_model ctl_u (.go_in(go), .known_in(known), .byte_in(bv), .cmd_valid_out(cv),
        .cmd_byte_out(cb), .cmd_known_out(ck));
    esc_status_logic dut_u (.core_clk_in, .resetn_in, .init_align_err_in(e[0]),
        .init_offset_err_in(e[1]), .init_part_err_in(e[2]), .init_alim_err_in(e[3]),
        .init_ibus_err_in(e[4]), .init_csum_err_in(e[5]), .wdog_restart_in(e[6]),
        .parity_err_in(e[7]), .frame_csum_err_in(e[8]), .cmd_valid_in(cv), .cmd_byte_in(cb),
        .cmd_known_in(ck), .len_err_in(e[10]), .arg_err_in(e[11]), .wr_req_in(e[12]),
        .field_wprot_in(e[12]), .code_valid_in(e[13]), .code_in(8'hAA), .code_load_in(e[13]),
        .resize_fail_in(e[14]), .addr_out_of_field_in(e[15]), .field_missing_in(e[16]),
        .overspeed_in(e[20]), .analog_mon_err_in(e[17]), .tx_current_crit_in(e[18]),
        .work_mem_err_in(e[19]), .status_clear_in(e[21]), .status_out(so),
        .status_valid_out(sv), .status_reply_out(rep), .wr_refused_out(wref),
        .access_reject_out(arej), .code0_out(c0));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic put(input logic [21:0] v, input logic rd);
        logic [7:0] old;
        old = ex;
        @(negedge core_clk_in);
        e = v;
        go = v[9] | rd;
        known = rd;
        bv = rd ? 8'h50 : 8'($random(seed));
        @(negedge core_clk_in);
        e = '0;
        go = 1'b0;
        if (v[21]) ex = 8'h00;
        for (int i = 0; i < 21; i++) begin
            if (v[i]) ex = cd[i];
        end
        chk("valid", sv, rd);
        if (rd) chk("reply", rep, old);
        chk("status", so, ex);
        chk("refused", wref, v[12]);
        chk("reject", arej, v[15] | v[16]);
    endtask : put
    task close_out;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end
    initial begin
        #100000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (8) @(negedge core_clk_in);
        resetn_in = 1'b1;
        chk("status", so, 8'h00);
        chk("code0", c0, 8'h55);
        for (int i = 0; i < 22; i++) begin
            put(22'h1 << i, 1'b0);
            put('0, 1'b1);
        end
        $display("single events done");
        for (int k = 0; k < 300; k++) begin
            r = $random(seed) & $random(seed);
            put(r[21:0], r[31] & !r[9]);
        end
        $display("random events done");
        @(negedge core_clk_in);
        resetn_in = 1'b0;
        ex = 8'h00;
        #1;
        chk("status", so, 8'h00);
        @(negedge core_clk_in);
        resetn_in = 1'b1;
        put('0, 1'b1);
        $display("second reset done");
        close_out;
    end
endmodule : tb_esc_status_logic
bind esc_status_logic esc_status_logic_checker chk_u (.*);
